// [supervisor_pkg.sv]
/*
 * Shared constants for the supply supervisor: time figures, derived
 * cycle counts, state codes and synchroniser reset values.
 * Assumes a single 50 MHz system clock.
 */
package supervisor_pkg;

	// Clock rate in kHz, keeps the products inside 32 bits
	localparam int CLK_KHZ = 50000;

	// Reset hold after every cause clears, in ms
	localparam int RESET_TIMEOUT_MS = 215;
	// Kick silence before watchdog expiry, in ms
	localparam int WDOG_TIMEOUT_MS = 1500;

	// Nominal figures divide evenly, so no rounding is lost
	localparam int RESET_TIMEOUT_CYCLES = RESET_TIMEOUT_MS * CLK_KHZ;
	localparam int WDOG_TIMEOUT_CYCLES = WDOG_TIMEOUT_MS * CLK_KHZ;

	// Wide enough for the watchdog count
	localparam int TIMER_W = 27;

	// Synchroniser bit positions
	localparam int SYNC_W = 4;
	localparam int SYNC_UV = 0;
	localparam int SYNC_MR = 1;
	localparam int SYNC_KICK = 2;
	localparam int SYNC_FLOAT = 3;
	// Idle levels: supply fine, manual reset high, kick low, driven
	localparam logic [SYNC_W-1:0] SYNC_RST = 4'h2;

	typedef enum logic [1:0] {
		ST_ASSERT = 2'h0,
		ST_TIMEOUT = 2'h1,
		ST_RUN = 2'h2
	} sup_state_t;

endpackage : supervisor_pkg

// [timer_if.sv]
/*
 * Carrier between the supervisor and its interval timers.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface timer_if;
	logic clear;
	logic run;
	logic done;

	modport ctrl (output clear, output run, input done);
	modport tmr (input clear, input run, output done);
endinterface : timer_if

`default_nettype wire

// [interval_timer.sv]
/*
 * Interval timer: counts while run, restarts on clear, flags done
 * in the cycle that completes LIMIT counting cycles.
 * Assumes clear and run come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module interval_timer #(
	parameter int WIDTH = supervisor_pkg::TIMER_W,
	parameter int LIMIT = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	timer_if.tmr t
);

	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] cnt_nxt;
	logic at_end;

	////////////////////////////////////////////////////////////////////
	assign at_end = (cnt_r == WIDTH'(LIMIT - 1));
	assign t.done = t.run && !t.clear && at_end;

	always_comb begin
		cnt_nxt = cnt_r;
		if (t.clear || t.done) begin
			cnt_nxt = '0;
		end else if (t.run) begin
			cnt_nxt = cnt_r + WIDTH'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule : interval_timer

`default_nettype wire

// [supervisor_reset_watchdog.sv]
/*
 * Supervisory reset generator: holds the processor reset while the
 * supply is low, the manual reset is pulled low, or the watchdog
 * expires, then for a fixed timeout after every cause has cleared.
 * Assumes the undervoltage flag and the kick-float flag come from
 * the analog front end; all pins arrive asynchronously.
 */
`timescale 1ns/10ps
`default_nettype none

// Function
// RQ1: Undervoltage flag asserts the reset output.
// RQ2: Reset held timeout after supply recovers.
// RQ3: Reset timeout nominally 215 milliseconds.
// RQ4: Manual input low asserts reset.
// RQ5: Manual reset held while low, plus timeout.
// RQ6: Kick idle 1.5 s expires watchdog, resets.
// RQ7: Kick edges and reset clear watchdog timer.
// RQ8: Undriven kick input disables the watchdog.
// RQ9: Processor keeps kick low/undriven during timeout.
// RQ10: Active-low build: high, low, high after timeout.
// RQ11: Active-high build: low, high, low after timeout.
// RQ12: Countdown starts only when every cause clears.
// RQ13: Unused manual input left open or high.
// RQ14: Counters time periods; timeout restarts on cause.
module supervisor_reset_watchdog #(
	parameter int RST_CYCLES = supervisor_pkg::RESET_TIMEOUT_CYCLES,
	parameter int WDOG_CYCLES = supervisor_pkg::WDOG_TIMEOUT_CYCLES,
	parameter int CNT_W = supervisor_pkg::TIMER_W,
	parameter bit OUT_ACTIVE_LOW = 1'h1
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic undervolt_i,
	input wire logic manual_reset_in_low_i,
	input wire logic watchdog_kick_in_i,
	input wire logic kick_undriven_i,
	output logic reset_out_low_active_o
);

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [supervisor_pkg::SYNC_W-1:0] meta_r;
	logic [supervisor_pkg::SYNC_W-1:0] meta_nxt;
	logic [supervisor_pkg::SYNC_W-1:0] sync_r;
	logic [supervisor_pkg::SYNC_W-1:0] sync_nxt;
	logic kick_prev_r;
	logic kick_prev_nxt;

	always_comb begin
		meta_nxt = meta_r;
		meta_nxt[supervisor_pkg::SYNC_UV] = undervolt_i;
		meta_nxt[supervisor_pkg::SYNC_MR] = manual_reset_in_low_i;
		meta_nxt[supervisor_pkg::SYNC_KICK] = watchdog_kick_in_i;
		meta_nxt[supervisor_pkg::SYNC_FLOAT] = kick_undriven_i;
		sync_nxt = meta_r;
		kick_prev_nxt = sync_r[supervisor_pkg::SYNC_KICK];
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_r <= supervisor_pkg::SYNC_RST;
			sync_r <= supervisor_pkg::SYNC_RST;
			kick_prev_r <= 1'h0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
			kick_prev_r <= kick_prev_nxt;
		end
	end

	logic uv_s;
	logic mr_low_s;
	logic kick_s;
	logic float_s;

	assign uv_s = sync_r[supervisor_pkg::SYNC_UV];
	assign mr_low_s = !sync_r[supervisor_pkg::SYNC_MR];
	assign kick_s = sync_r[supervisor_pkg::SYNC_KICK];
	assign float_s = sync_r[supervisor_pkg::SYNC_FLOAT];

	////////////////////////////////////////////////////////////////////
	// Timers

	timer_if rto ();
	timer_if wdt ();

	supervisor_pkg::sup_state_t state_r;
	supervisor_pkg::sup_state_t state_nxt;
	logic rst_active;
	logic kick_edge;
	logic wd_expire;
	logic cause;

	assign rst_active = (state_r != supervisor_pkg::ST_RUN);
	assign kick_edge = kick_s ^ kick_prev_r;
	assign wd_expire = wdt.done;
	assign cause = uv_s || mr_low_s || wd_expire; // RQ1 RQ4 RQ6

	// Timeout counts only in its state, restarts on any cause
	assign rto.clear = cause || !(state_r == supervisor_pkg::ST_TIMEOUT); // RQ14
	assign rto.run = (state_r == supervisor_pkg::ST_TIMEOUT); // RQ2

	// Float check relies on the front end flagging a tri-stated pin
	assign wdt.clear = kick_edge || rst_active || float_s; // RQ7 RQ8
	assign wdt.run = 1'h1;

	interval_timer #(
		.WIDTH(CNT_W),
		.LIMIT(RST_CYCLES) // RQ3
	) u_reset_timer (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.t(rto)
	);

	interval_timer #(
		.WIDTH(CNT_W),
		.LIMIT(WDOG_CYCLES) // RQ6
	) u_wdog_timer (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.t(wdt)
	);

	////////////////////////////////////////////////////////////////////
	// Reset sequencer

	logic pin_r;
	logic pin_nxt;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			supervisor_pkg::ST_ASSERT: begin
				if (!cause) begin
					state_nxt = supervisor_pkg::ST_TIMEOUT; // RQ12
				end
			end
			supervisor_pkg::ST_TIMEOUT: begin
				if (cause) begin
					state_nxt = supervisor_pkg::ST_ASSERT; // RQ5
				end else if (rto.done) begin
					state_nxt = supervisor_pkg::ST_RUN; // RQ2
				end
			end
			supervisor_pkg::ST_RUN: begin
				if (cause) begin
					state_nxt = supervisor_pkg::ST_ASSERT;
				end
			end
			default: begin
				state_nxt = supervisor_pkg::ST_ASSERT;
			end
		endcase
		// Output polarity is fixed per build
		if (OUT_ACTIVE_LOW) begin
			pin_nxt = !(state_nxt != supervisor_pkg::ST_RUN); // RQ10
		end else begin
			pin_nxt = (state_nxt != supervisor_pkg::ST_RUN); // RQ11
		end
	end

	// Power-on acts like a cause: full timeout before first release
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_r <= supervisor_pkg::ST_ASSERT;
			pin_r <= !OUT_ACTIVE_LOW;
		end else begin
			state_r <= state_nxt;
			pin_r <= pin_nxt;
		end
	end

	assign reset_out_low_active_o = pin_r;

	////////////////////////////////////////////////////////////////////
	// Checking helpers

	logic [CNT_W-1:0] hold_cnt_r;
	logic [CNT_W-1:0] hold_cnt_nxt;
	logic [CNT_W-1:0] idle_cnt_r;
	logic [CNT_W-1:0] idle_cnt_nxt;

	always_comb begin
		hold_cnt_nxt = '0;
		if (state_r == supervisor_pkg::ST_TIMEOUT && !cause) begin
			hold_cnt_nxt = hold_cnt_r + CNT_W'(1);
		end
		idle_cnt_nxt = '0;
		if (!wdt.clear && !wd_expire) begin
			idle_cnt_nxt = idle_cnt_r + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			hold_cnt_r <= '0;
			idle_cnt_r <= '0;
		end else begin
			hold_cnt_r <= hold_cnt_nxt;
			idle_cnt_r <= idle_cnt_nxt;
		end
	end

	logic asserted_lvl;
	assign asserted_lvl = !OUT_ACTIVE_LOW;

	////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_uv_asserts_reset: // RQ1
	assert property (uv_s |-> ##2 reset_out_low_active_o == asserted_lvl)
	else $error("Undervoltage did not assert reset");

	a_mr_asserts_reset: // RQ4
	assert property (mr_low_s |=> state_r == supervisor_pkg::ST_ASSERT
		##1 reset_out_low_active_o == asserted_lvl)
	else $error("Manual reset did not assert reset");

	a_mr_holds_low: // RQ5
	assert property (mr_low_s [*2] |->
		state_r == supervisor_pkg::ST_ASSERT)
	else $error("Reset released while manual input low");

	a_release_after_timeout: // RQ2
	assert property ($rose(state_r == supervisor_pkg::ST_RUN) |->
		$past(hold_cnt_r) == CNT_W'(RST_CYCLES - 1))
	else $error("Reset released before full timeout");

	a_timeout_restart: // RQ14
	assert property (cause |=> hold_cnt_r == '0 &&
		u_reset_timer.cnt_r == '0)
	else $error("Timeout count not restarted by cause");

	a_countdown_clear: // RQ12
	assert property ($rose(state_r == supervisor_pkg::ST_TIMEOUT) |->
		$past(state_r) == supervisor_pkg::ST_ASSERT && !$past(cause))
	else $error("Countdown began while a cause persisted");

	a_wdog_expiry_time: // RQ6
	assert property (wd_expire |->
		idle_cnt_r == CNT_W'(WDOG_CYCLES - 1)
		##1 state_r == supervisor_pkg::ST_ASSERT)
	else $error("Watchdog expiry at wrong time");

	a_wdog_clears: // RQ7
	assert property ((kick_edge || rst_active) |-> !wd_expire
		##1 idle_cnt_r == '0)
	else $error("Watchdog timer not cleared");

	a_wdog_float_off: // RQ8
	assert property (float_s |-> !wd_expire)
	else $error("Watchdog fired with undriven kick");

	a_low_build_level: // RQ10
	assert property (OUT_ACTIVE_LOW |-> (reset_out_low_active_o ==
		(state_r == supervisor_pkg::ST_RUN)))
	else $error("Active-low output level wrong");

	a_high_build_level: // RQ11
	assert property (!OUT_ACTIVE_LOW |-> (reset_out_low_active_o ==
		(state_r != supervisor_pkg::ST_RUN)))
	else $error("Active-high output level wrong");

	a_timer_len: // RQ3
	assert property (rto.done |-> hold_cnt_r == CNT_W'(RST_CYCLES - 1))
	else $error("Timeout length differs from set count");

	a_no_release_cause: // RQ12
	assert property (cause |=> reset_out_low_active_o == asserted_lvl)
	else $error("Reset released while a cause persisted");

	a_uv_holds_reset: // RQ1
	assert property (uv_s [*2] |-> reset_out_low_active_o == asserted_lvl)
	else $error("Reset not held during undervoltage");

	// Only a finished countdown may release the processor
	a_run_after_done: // RQ2
	assert property ($rose(state_r == supervisor_pkg::ST_RUN) |->
		$past(rto.done))
	else $error("Reset released without a finished countdown");

	// Bounded to suit the short simulation timeout
	c_uv_release:
	cover property (uv_s ##1 !uv_s [*2] ##[1:1000]
		state_r == supervisor_pkg::ST_RUN);

	c_float_idle:
	cover property (float_s && state_r == supervisor_pkg::ST_RUN);

	c_manual_cycle:
	cover property (state_r == supervisor_pkg::ST_RUN ##1 mr_low_s);

	c_wdog_fire:
	cover property (wd_expire);

	c_timeout_broken:
	cover property (state_r == supervisor_pkg::ST_TIMEOUT && cause);

endmodule : supervisor_reset_watchdog

`default_nettype wire

// [cpu_model.sv]
/*
 * Behavioural model of the supervised processor: toggles the kick
 * pin while allowed, or releases it to turn the watchdog off.
 * Assumes it shares the supervisor's clock and sees its reset.
 */
`timescale 1ns/10ps
`default_nettype none

module cpu_model #(
	parameter int KICK_GAP = 10
) (
	input wire logic clk_i,
	input wire logic in_reset_i,
	input wire logic kick_on_i,
	input wire logic float_on_i,
	output logic kick_o,
	output logic undriven_o
);
	int gap_r = 0;
	logic kick_r = 1'h0;

	////////////////////////////////////////////////////////////////////
	// Kick held low while in reset or when kicking is stopped
	always_ff @(posedge clk_i) begin
		if (in_reset_i || !kick_on_i) begin
			kick_r <= 1'h0;
			gap_r <= 0;
		end else if (gap_r == KICK_GAP - 1) begin
			kick_r <= ~kick_r;
			gap_r <= 0;
		end else begin
			gap_r <= gap_r + 1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Released pin has no pull: it rests at the inverse of the driven
	// level, so only float detection keeps the watchdog quiet
	assign kick_o = float_on_i ? !kick_r : kick_r;
	assign undriven_o = float_on_i;
endmodule : cpu_model

`default_nettype wire

// [supervisor_reset_watchdog_bench.sv]
/*
 * Self-checking bench for the supply supervisor, both polarities.
 * Assumes shortened timeout parameters and the processor model.
 */
`timescale 1ns/10ps
`default_nettype none

module supervisor_reset_watchdog_bench;
	localparam int RST_C = 20;
	localparam int WDOG_C = 50;
	logic clk_i = 1'h0;
	logic sys_rst_i = 1'h1;
	logic uv = 1'h0;
	logic mr_low = 1'h1;
	logic kick_on = 1'h0;
	logic float_on = 1'h1;
	logic pol_on = 1'h0;
	logic kick;
	logic undriven;
	logic out_lo;
	logic out_hi;
	int mismatches = 0;
	int check_count = 0;

	initial begin
		forever #10 clk_i = ~clk_i;
	end

	supervisor_reset_watchdog #(.RST_CYCLES(RST_C), .WDOG_CYCLES(WDOG_C),
		.OUT_ACTIVE_LOW(1'h1)) supervisor_reset_watchdog_i (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .undervolt_i(uv),
		.manual_reset_in_low_i(mr_low), .watchdog_kick_in_i(kick),
		.kick_undriven_i(undriven), .reset_out_low_active_o(out_lo));
	supervisor_reset_watchdog #(.RST_CYCLES(RST_C), .WDOG_CYCLES(WDOG_C),
		.OUT_ACTIVE_LOW(1'h0)) supervisor_reset_watchdog_i2 (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .undervolt_i(uv),
		.manual_reset_in_low_i(mr_low), .watchdog_kick_in_i(kick),
		.kick_undriven_i(undriven), .reset_out_low_active_o(out_hi));
	cpu_model cpu_model_i (.clk_i(clk_i), .in_reset_i(!out_lo),
		.kick_on_i(kick_on), .float_on_i(float_on), .kick_o(kick),
		.undriven_o(undriven));

	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		if (mismatches == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	// Counts samples of either output where the reset level differs from lvl, so a cycle with both outputs wrong counts twice
	task automatic holds(input logic lvl, input int n);
		int bad;
		bad = 0;
		repeat (n) begin
			@(negedge clk_i);
			if (out_lo !== !lvl) bad++;
			if (out_hi !== lvl) bad++;
		end
		check(bad, 0);
	endtask : holds

	task automatic wait_for(input logic lvl, input int max, output int n);
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (out_lo !== !lvl && n < max);
	endtask : wait_for

	task automatic release_chk();
		int n;
		holds(1'h1, RST_C - 2);
		wait_for(1'h0, 10, n);
		check(n >= 2 && n < 9, 1);
	endtask : release_chk

	task automatic assert_chk();
		int n;
		wait_for(1'h1, 6, n);
		check(n < 6, 1);
		holds(1'h1, 30);
	endtask : assert_chk

	////////////////////////////////////////////////////////////////////
	task automatic t_powerup();
		int n;
		wait_for(1'h0, RST_C + 10, n);
		check(n >= RST_C && n < RST_C + 10, 1);
	endtask : t_powerup

	task automatic t_undervolt();
		@(posedge clk_i) uv <= 1'h1;
		assert_chk();
		@(posedge clk_i) uv <= 1'h0;
		release_chk();
	endtask : t_undervolt

	task automatic t_manual();
		@(posedge clk_i) mr_low <= 1'h0;
		assert_chk();
		@(posedge clk_i) mr_low <= 1'h1;
		release_chk();
	endtask : t_manual

	// A cause inside the timeout must restart it in full
	task automatic t_restart();
		@(posedge clk_i) uv <= 1'h1;
		assert_chk();
		@(posedge clk_i) uv <= 1'h0;
		holds(1'h1, 10);
		@(posedge clk_i) mr_low <= 1'h0;
		repeat (3) @(posedge clk_i);
		mr_low <= 1'h1;
		release_chk();
	endtask : t_restart

	task automatic t_watchdog();
		int n;
		@(posedge clk_i) float_on <= 1'h0;
		kick_on <= 1'h1;
		holds(1'h0, 200);
		@(posedge clk_i) kick_on <= 1'h0;
		wait_for(1'h1, WDOG_C + 20, n);
		check(n >= WDOG_C - 12 && n < WDOG_C + 20, 1);
		release_chk();
		wait_for(1'h1, WDOG_C + 10, n);
		check(n >= WDOG_C - 2 && n < WDOG_C + 10, 1);
		release_chk();
	endtask : t_watchdog

	task automatic t_float();
		@(posedge clk_i) float_on <= 1'h1;
		holds(1'h0, 200);
	endtask : t_float

	////////////////////////////////////////////////////////////////////
	always @(negedge clk_i) begin
		if (pol_on) check(out_hi, !out_lo);
	end

	initial begin
		#100us;
		mismatches++;
		tally_and_finish();
	end

	initial begin
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		pol_on <= 1'h1;
		t_powerup();
		t_undervolt();
		t_manual();
		t_restart();
		t_watchdog();
		t_float();
		tally_and_finish();
	end
endmodule : supervisor_reset_watchdog_bench

`default_nettype wire
